// ==== include/emacir_pkg.sv ====
package emacir_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_MASK     = 8'h04;
  localparam logic [7:0] OFS_ADDR_HI  = 8'h08;
  localparam logic [7:0] OFS_ADDR_LO  = 8'h0C;
  localparam logic [7:0] OFS_WAKE     = 8'h10;
  localparam logic [7:0] OFS_EV_STAT  = 8'h14;
  localparam logic [7:0] OFS_EV_MASK  = 8'h18;

  // interrupt status and mask field positions
  localparam int BIT_TIME_TARGET    = 9;
  localparam int BIT_COUNTER_TX     = 6;
  localparam int BIT_COUNTER_RX     = 5;
  localparam int BIT_COUNTER_SUM    = 4;
  localparam int BIT_WAKE_EVENT     = 3;

  // power wake control and status fields
  localparam int BIT_POWER_DOWN     = 0;
  localparam int BIT_MAGIC_ENABLE   = 1;
  localparam int BIT_REMOTE_ENABLE  = 2;
  localparam int BIT_WOKE_MAGIC     = 5;
  localparam int BIT_WOKE_REMOTE    = 6;

  // address high word fields and address reset values
  localparam int BIT_ADDRESS_VALID  = 31;
  localparam logic [14:0] ADDR_HI_RESVD  = 15'h0010;
  localparam logic [15:0] ADDR_HI_RESET  = 16'hFFFF;
  localparam logic [31:0] ADDR_LO_RESET  = 32'hFFFFFFFF;

  // sticky event bits
  localparam int EV_TIME_HIT        = 0;
  localparam int EV_WAKE_HIT        = 1;
  localparam int EV_ADDR_SYNCED     = 2;
  localparam int EV_WIDTH           = 3;

  // address transfer into the receive side, in core clock cycles
  localparam int SYNC_CYCLES        = 4;

  // station address as seen by filter and pause insertion
  typedef struct packed {
    logic [15:0] upper;
    logic [31:0] lower;
  } emacir_addr_t;

  // wake sources from the frame receiver
  typedef struct packed {
    logic magic_packet;
    logic remote_frame;
  } emacir_wake_t;

endpackage

// ==== verilog/emacir_regs.sv ====
module emacir_regs #(
  parameter int TX_BITS   = 32,
  parameter int RX_BITS   = 32,
  parameter bit ADDR_SYNC = 1'b1
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // timestamp engine
  input  wire logic                  timestamp_enable,
  input  wire logic [63:0]           system_time,
  input  wire logic [63:0]           target_time,
  // management counter interrupt registers
  input  wire logic [TX_BITS-1:0]    counter_tx_interrupt_reg,
  input  wire logic [RX_BITS-1:0]    counter_rx_interrupt_reg,
  // receiver wake sources, one-cycle pulses
  input  wire emacir_pkg::emacir_wake_t wake_seen,
  // configuration
  input  wire logic                  big_endian,
  // address and power-down outputs
  output emacir_pkg::emacir_addr_t   filter_address,
  output emacir_pkg::emacir_addr_t   synced_address,
  output logic                       power_down,
  // interrupt
  output logic                       irq
);

  // register state
  logic                              time_target_flag;
  logic                              time_reached_q;
  logic                              time_target_mask;
  logic                              wake_event_mask;
  logic                              magic_enable;
  logic                              remote_enable;
  logic                              woke_by_magic_packet;
  logic                              woke_by_remote_frame;
  logic [15:0]                       primary_address_upper;
  logic [31:0]                       station_address_primary_low;
  logic [emacir_pkg::EV_WIDTH-1:0]   ev_status;
  logic [emacir_pkg::EV_WIDTH-1:0]   ev_mask;
  logic [2:0]                        sync_cnt;
  logic                              sync_busy;
  emacir_pkg::emacir_addr_t          sync_hold;

  // decoded bus activity and derived combinational signals
  logic                              done;
  logic                              wr_done;
  logic                              rd_done;
  logic                              mapped;
  logic                              time_reached;
  logic                              counter_tx_flag;
  logic                              counter_rx_flag;
  logic                              counter_summary_flag;
  logic                              wake_event_flag;
  logic                              mask_live;
  logic                              magic_hit;
  logic                              remote_hit;
  logic                              sync_trigger;
  logic [15:0]                       next_status;
  logic [15:0]                       next_mask;
  logic [31:0]                       next_addr_hi;
  logic [31:0]                       next_rdata;
  logic [emacir_pkg::EV_WIDTH-1:0]   ev_set;

  // merge a written word into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true when paddr equals the given offset; callers gate it with wr_done or rd_done
  function automatic logic hit(input logic [7:0] ofs);
    return paddr == ofs;
  endfunction

  // one wait state keeps read data coming from a flop
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= psel & penable & ~pready;
    end
  end

  assign done    = psel & penable & pready;
  assign wr_done = done & pwrite;
  assign rd_done = done & ~pwrite;
  assign mapped  = (paddr == emacir_pkg::OFS_STATUS) | (paddr == emacir_pkg::OFS_MASK)
                 | (paddr == emacir_pkg::OFS_ADDR_HI) | (paddr == emacir_pkg::OFS_ADDR_LO)
                 | (paddr == emacir_pkg::OFS_WAKE) | (paddr == emacir_pkg::OFS_EV_STAT)
                 | (paddr == emacir_pkg::OFS_EV_MASK);

  // unmapped offsets answer with an error, writes there are dropped
  assign pslverr = done & ~mapped;

  // level flags derived from the counter and wake state, and the live time mask
  // tx pending OR
  assign counter_tx_flag      = |counter_tx_interrupt_reg;
  assign counter_rx_flag      = |counter_rx_interrupt_reg;
  assign counter_summary_flag = counter_tx_flag | counter_rx_flag;
  assign wake_event_flag      = woke_by_magic_packet | woke_by_remote_frame;
  assign mask_live            = time_target_mask & timestamp_enable;

  assign time_reached = system_time >= target_time;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      time_reached_q <= 1'b0;
    end
    else
    begin
      time_reached_q <= time_reached;
    end
  end

  // time flag: a new hit in the clearing read cycle wins
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      time_target_flag <= 1'b0;
    end
    else if (time_reached & ~time_reached_q)
    begin
      time_target_flag <= 1'b1;
    end
    else if (rd_done & hit(emacir_pkg::OFS_STATUS))
    begin
      time_target_flag <= 1'b0;
    end
  end

  // wake hits only count while powered down with the source enabled
  // wake in power-down
  assign magic_hit  = wake_seen.magic_packet & power_down & magic_enable;
  assign remote_hit = wake_seen.remote_frame & power_down & remote_enable;

  // power wake control: enables, power-down, read-clear wake reasons
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      power_down           <= 1'b0;
      magic_enable         <= 1'b0;
      remote_enable        <= 1'b0;
      woke_by_magic_packet <= 1'b0;
      woke_by_remote_frame <= 1'b0;
    end
    else
    begin
      if (wr_done & hit(emacir_pkg::OFS_WAKE))
      begin
        magic_enable  <= pwdata[emacir_pkg::BIT_MAGIC_ENABLE];
        remote_enable <= pwdata[emacir_pkg::BIT_REMOTE_ENABLE];
        power_down    <= pwdata[emacir_pkg::BIT_POWER_DOWN];
      end
      // a wake ends power-down on its own
      if (magic_hit | remote_hit)
      begin
        power_down <= 1'b0;
      end
      if (rd_done & hit(emacir_pkg::OFS_WAKE))
      begin
        woke_by_magic_packet <= 1'b0;
        woke_by_remote_frame <= 1'b0;
      end
      if (magic_hit)
      begin
        woke_by_magic_packet <= 1'b1;
      end
      if (remote_hit)
      begin
        woke_by_remote_frame <= 1'b1;
      end
    end
  end

  // interrupt masks; reserved positions never store
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      time_target_mask <= 1'b0;
      wake_event_mask  <= 1'b0;
    end
    else if (wr_done & hit(emacir_pkg::OFS_MASK))
    begin
      if (timestamp_enable)
      begin
        time_target_mask <= pwdata[emacir_pkg::BIT_TIME_TARGET];
      end
      wake_event_mask <= pwdata[emacir_pkg::BIT_WAKE_EVENT];
    end
  end

  // station address registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      primary_address_upper       <= emacir_pkg::ADDR_HI_RESET;
      station_address_primary_low <= emacir_pkg::ADDR_LO_RESET;
    end
    else if (wr_done & hit(emacir_pkg::OFS_ADDR_HI))
    begin
      primary_address_upper <= next_addr_hi[15:0];
    end
    else if (wr_done & hit(emacir_pkg::OFS_ADDR_LO))
    begin
      station_address_primary_low <= merge(station_address_primary_low,
                                           pwdata, pstrb);
    end
  end

  assign next_addr_hi = merge({16'h0000, primary_address_upper}, pwdata, pstrb);

  assign filter_address = '{upper: primary_address_upper,
                            lower: station_address_primary_low};

  assign sync_trigger = wr_done & (paddr == emacir_pkg::OFS_ADDR_LO)
                      & (big_endian ? pstrb[0] : pstrb[3]);

  // receive-side copy; the delay models the destination handshake so
  // software sees when a new address is really in use
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_busy      <= 1'b0;
      sync_cnt       <= 3'h0;
      sync_hold      <= '{upper: emacir_pkg::ADDR_HI_RESET,
                          lower: emacir_pkg::ADDR_LO_RESET};
      synced_address <= '{upper: emacir_pkg::ADDR_HI_RESET,
                          lower: emacir_pkg::ADDR_LO_RESET};
    end
    else if (!ADDR_SYNC)
    begin
      synced_address <= filter_address;
    end
    else if (sync_trigger)
    begin
      sync_busy <= 1'b1;
      sync_cnt  <= 3'(emacir_pkg::SYNC_CYCLES - 1);
      sync_hold <= '{upper: primary_address_upper,
                     lower: merge(station_address_primary_low, pwdata, pstrb)};
    end
    else if (sync_busy)
    begin
      if (sync_cnt == 3'h0)
      begin
        sync_busy      <= 1'b0;
        synced_address <= sync_hold;
      end
      else
      begin
        sync_cnt <= sync_cnt - 3'h1;
      end
    end
  end

  // sticky events for the shared interrupt line
  assign ev_set[emacir_pkg::EV_TIME_HIT]    = time_reached & ~time_reached_q;
  assign ev_set[emacir_pkg::EV_WAKE_HIT]    = magic_hit | remote_hit;
  assign ev_set[emacir_pkg::EV_ADDR_SYNCED] = sync_busy & (sync_cnt == 3'h0);

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ev_status <= '0;
    end
    else if (wr_done & hit(emacir_pkg::OFS_EV_STAT))
    begin
      ev_status <= (ev_status & ~pwdata[emacir_pkg::EV_WIDTH-1:0]) | ev_set;
    end
    else
    begin
      ev_status <= ev_status | ev_set;
    end
  end

  // event mask, one enables the bit onto the interrupt line
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ev_mask <= '0;
    end
    else if (wr_done & hit(emacir_pkg::OFS_EV_MASK))
    begin
      ev_mask <= pwdata[emacir_pkg::EV_WIDTH-1:0];
    end
  end

  // status and mask images, reserved bits zero
  always_comb
  begin
    next_status = 16'h0000;
    next_status[emacir_pkg::BIT_TIME_TARGET] = time_target_flag;
    next_status[emacir_pkg::BIT_COUNTER_TX]  = counter_tx_flag;
    next_status[emacir_pkg::BIT_COUNTER_RX]  = counter_rx_flag;
    next_status[emacir_pkg::BIT_COUNTER_SUM] = counter_summary_flag;
    next_status[emacir_pkg::BIT_WAKE_EVENT]  = wake_event_flag;
    next_mask = 16'h0000;
    next_mask[emacir_pkg::BIT_TIME_TARGET]   = mask_live;
    next_mask[emacir_pkg::BIT_WAKE_EVENT]    = wake_event_mask;
  end

  // read data multiplexer
  always_comb
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      emacir_pkg::OFS_STATUS:  next_rdata = {16'h0000, next_status};
      emacir_pkg::OFS_MASK:    next_rdata = {16'h0000, next_mask};
      emacir_pkg::OFS_ADDR_HI: next_rdata = {1'b1, emacir_pkg::ADDR_HI_RESVD,
                                             primary_address_upper};
      emacir_pkg::OFS_ADDR_LO: next_rdata = station_address_primary_low;
      emacir_pkg::OFS_WAKE:
      begin
        next_rdata[emacir_pkg::BIT_POWER_DOWN]    = power_down;
        next_rdata[emacir_pkg::BIT_MAGIC_ENABLE]  = magic_enable;
        next_rdata[emacir_pkg::BIT_REMOTE_ENABLE] = remote_enable;
        next_rdata[emacir_pkg::BIT_WOKE_MAGIC]    = woke_by_magic_packet;
        next_rdata[emacir_pkg::BIT_WOKE_REMOTE]   = woke_by_remote_frame;
      end
      emacir_pkg::OFS_EV_STAT: next_rdata[emacir_pkg::EV_WIDTH-1:0] = ev_status;
      emacir_pkg::OFS_EV_MASK: next_rdata[emacir_pkg::EV_WIDTH-1:0] = ev_mask;
      default:                 next_rdata = 32'h00000000;
    endcase
  end

  // read data captured in the first access cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prdata <= 32'h00000000;
    end
    else if (psel & penable & ~pready & ~pwrite)
    begin
      prdata <= next_rdata;
    end
  end

  // interrupt line from flops; counter flags have no mask
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= (time_target_flag & ~mask_live)
           | (wake_event_flag & ~wake_event_mask)
           | counter_summary_flag
           | (|(ev_status & ev_mask));
    end
  end

endmodule

// ==== verif/emacir_regs_properties.sv ====
module emacir_chk #(
  parameter int TX_BITS = 32,
  parameter int RX_BITS = 32
) (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     sys_rst,
  // apb side
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [3:0]               pstrb,
  input wire logic                     pready,
  input wire logic [31:0]              prdata,
  // sources and results
  input wire logic                     big_endian,
  input wire logic [63:0]              system_time,
  input wire logic [63:0]              target_time,
  input wire logic [TX_BITS-1:0]       counter_tx_interrupt_reg,
  input wire logic [RX_BITS-1:0]       counter_rx_interrupt_reg,
  input wire emacir_pkg::emacir_addr_t filter_address,
  input wire emacir_pkg::emacir_addr_t synced_address,
  input wire logic                     irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // history of the counter inputs: a flag is only judged once its cause sat still
  logic [3:0] tx_h;
  logic [3:0] rx_h;
  logic       fin;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_h <= 4'h0;
      rx_h <= 4'h0;
    end
    else
    begin
      tx_h <= {tx_h[2:0], |counter_tx_interrupt_reg};
      rx_h <= {rx_h[2:0], |counter_rx_interrupt_reg};
    end
  end

  // completion edge of an apb transfer
  assign fin = psel && penable && pready;

  sequence st_rd;
    fin && !pwrite && paddr == emacir_pkg::OFS_STATUS;
  endsequence
  sequence st_rd_low;
    st_rd ##0 (system_time < target_time);
  endsequence
  sequence lo_trig;
    fin && pwrite && paddr == emacir_pkg::OFS_ADDR_LO && (big_endian ? pstrb[0] : pstrb[3]);
  endsequence

  chk_tx_flag:
    assert property (st_rd ##0 (tx_h == {4{tx_h[0]}}) |-> prdata[6] == tx_h[0])
    else $error("tx counter flag wrong");
  chk_rx_flag:
    assert property (st_rd ##0 (rx_h == {4{rx_h[0]}}) |-> prdata[5] == rx_h[0])
    else $error("rx counter flag wrong");
  chk_sum_flag:
    assert property (st_rd |-> prdata[4] == (prdata[6] | prdata[5]))
    else $error("summary flag wrong");
  chk_status_resvd:
    assert property (st_rd |-> (prdata & 32'hFFFFFD87) == 32'h0)
    else $error("status reserved bits set");
  chk_addr_valid:
    assert property (fin && !pwrite && paddr == emacir_pkg::OFS_ADDR_HI |-> prdata[31:16] == 16'h8010)
    else $error("address high top half wrong");
  chk_sync_copy:
    assert property (lo_trig |-> ##5 synced_address == filter_address)
    else $error("synced address not updated");
  chk_irq_counter:
    assert property (tx_h == 4'hF |-> irq)
    else $error("irq low with tx counter pending");
  chk_time_clear:
    assert property (st_rd_low ##1 (!fin && system_time < target_time)[*3] ##1 st_rd_low
                     |-> prdata[9] == 1'b0)
    else $error("time flag not cleared by read");
endmodule

bind emacir_regs emacir_chk #(
  .TX_BITS (TX_BITS),
  .RX_BITS (RX_BITS)
) u_chk (
  .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pstrb, .pready, .prdata,
  .big_endian, .system_time, .target_time, .counter_tx_interrupt_reg,
  .counter_rx_interrupt_reg, .filter_address, .synced_address, .irq
);

// ==== verif/tb_emac_irq_status_mask_and_addr0_high.sv ====
module tb_emac_irq_status_mask_and_addr0_high;
  timeunit 1ns;
  timeprecision 1ps;

  // design inputs, all valued at time zero
  logic                     core_clk = 1'b0;
  logic                     sys_rst = 1'b1;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0;
  logic [3:0]               pstrb = 4'h0;
  logic                     timestamp_enable = 1'b0;
  logic [63:0]              system_time = 64'h0;
  logic [63:0]              target_time = 64'hFF;
  logic [31:0]              counter_tx_interrupt_reg = 32'h0;
  logic [31:0]              counter_rx_interrupt_reg = 32'h0;
  emacir_pkg::emacir_wake_t wake_seen = 2'h0;
  logic                     big_endian = 1'b0;
  // outputs and bench state
  logic                     pready, pslverr, power_down, irq, rd_err;
  logic [31:0]              prdata;
  logic [31:0]              rd_data;
  emacir_pkg::emacir_addr_t filter_address;
  emacir_pkg::emacir_addr_t synced_address;
  int                       fail_count = 0;
  int                       tests_run = 0;

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  emacir_regs u_dut (
    .core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .timestamp_enable, .system_time, .target_time,
    .counter_tx_interrupt_reg, .counter_rx_interrupt_reg, .wake_seen, .big_endian,
    .filter_address, .synced_address, .power_down, .irq
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one apb transfer; pready, prdata and pslverr are taken at the completing
  // rising edge, and only then is the request released
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk({rd_err, rd_data}, {1'b0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(a, 1'b1, d, s);
  endtask

  task automatic pulse(input logic [1:0] v);
    @(posedge core_clk);
    wake_seen <= v;
    @(posedge core_clk);
    wake_seen <= 2'h0;
    settle(3);
  endtask

  // reset values, fixed fields, time mask gating, unmapped offset
  task automatic t_regs;
    rd(emacir_pkg::OFS_STATUS, 32'h0);
    rd(emacir_pkg::OFS_MASK, 32'h0);
    rd(emacir_pkg::OFS_ADDR_HI, 32'h8010FFFF);
    rd(emacir_pkg::OFS_ADDR_LO, 32'hFFFFFFFF);
    chk(filter_address, 64'hFFFFFFFFFFFF);
    wr(emacir_pkg::OFS_ADDR_HI, 32'h0000ABCD, 4'hF);
    rd(emacir_pkg::OFS_ADDR_HI, 32'h8010ABCD);
    chk(filter_address.upper, 64'hABCD);
    wr(emacir_pkg::OFS_MASK, 32'hFFFFFFFF, 4'hF);
    rd(emacir_pkg::OFS_MASK, 32'h8);
    @(posedge core_clk);
    timestamp_enable <= 1'b1;
    wr(emacir_pkg::OFS_MASK, 32'hFFFFFFFF, 4'hF);
    rd(emacir_pkg::OFS_MASK, 32'h208);
    wr(emacir_pkg::OFS_MASK, 32'h0, 4'hF);
    apb(8'h40, 1'b0, 32'h0, 4'h0);
    chk({rd_err, rd_data}, 64'h100000000);
  endtask

  // counter flags and their summary
  task automatic t_counters;
    @(posedge core_clk);
    counter_tx_interrupt_reg <= 32'h80000000;
    settle(5);
    chk(irq, 1'b1);
    rd(emacir_pkg::OFS_STATUS, 32'h50);
    @(posedge core_clk);
    counter_tx_interrupt_reg <= 32'h0;
    counter_rx_interrupt_reg <= 32'h1;
    settle(5);
    rd(emacir_pkg::OFS_STATUS, 32'h30);
    @(posedge core_clk);
    counter_rx_interrupt_reg <= 32'h0;
    settle(5);
    chk(irq, 1'b0);
    rd(emacir_pkg::OFS_STATUS, 32'h0);
  endtask

  task automatic set_time(input logic [63:0] t);
    @(posedge core_clk);
    system_time <= t;
    settle(3);
  endtask

  // time target flag, read clear, mask, event register
  task automatic t_time;
    @(posedge core_clk);
    target_time <= 64'h200;
    set_time(64'h100);
    set_time(64'h200);
    chk(irq, 1'b1);
    rd(emacir_pkg::OFS_STATUS, 32'h200);
    rd(emacir_pkg::OFS_STATUS, 32'h0);
    wr(emacir_pkg::OFS_MASK, 32'h200, 4'hF);
    set_time(64'h100);
    set_time(64'h300);
    chk(irq, 1'b0);
    set_time(64'h100);
    rd(emacir_pkg::OFS_STATUS, 32'h200);
    rd(emacir_pkg::OFS_STATUS, 32'h0);
    wr(emacir_pkg::OFS_MASK, 32'h0, 4'hF);
    rd(emacir_pkg::OFS_EV_STAT, 32'h1);
    wr(emacir_pkg::OFS_EV_MASK, 32'h1, 4'hF);
    settle(3);
    chk(irq, 1'b1);
    wr(emacir_pkg::OFS_EV_STAT, 32'h1, 4'hF);
    settle(3);
    chk(irq, 1'b0);
    wr(emacir_pkg::OFS_EV_MASK, 32'h0, 4'hF);
  endtask

  // wake in power-down, unmasked then masked
  task automatic t_wake;
    wr(emacir_pkg::OFS_WAKE, 32'h3, 4'hF);
    settle(1);
    chk(power_down, 1'b1);
    pulse(2'h2);
    chk(power_down, 1'b0);
    chk(irq, 1'b1);
    rd(emacir_pkg::OFS_STATUS, 32'h8);
    rd(emacir_pkg::OFS_WAKE, 32'h22);
    rd(emacir_pkg::OFS_WAKE, 32'h2);
    rd(emacir_pkg::OFS_STATUS, 32'h0);
    wr(emacir_pkg::OFS_MASK, 32'h8, 4'hF);
    wr(emacir_pkg::OFS_WAKE, 32'h5, 4'hF);
    pulse(2'h1);
    chk(irq, 1'b0);
    rd(emacir_pkg::OFS_STATUS, 32'h8);
    rd(emacir_pkg::OFS_WAKE, 32'h44);
    rd(emacir_pkg::OFS_STATUS, 32'h0);
    wr(emacir_pkg::OFS_MASK, 32'h0, 4'hF);
  endtask

  // address lanes and the trigger lane of each byte order
  task automatic t_addr;
    wr(emacir_pkg::OFS_ADDR_LO, 32'h44332211, 4'h7);
    settle(8);
    chk(filter_address.lower, 64'hFF332211);
    chk(synced_address.lower, 64'hFFFFFFFF);
    wr(emacir_pkg::OFS_ADDR_LO, 32'h66554433, 4'h8);
    settle(8);
    chk(synced_address, 64'hABCD66332211);
    @(posedge core_clk);
    big_endian <= 1'b1;
    wr(emacir_pkg::OFS_ADDR_LO, 32'h11000000, 4'h8);
    settle(8);
    chk(synced_address, 64'hABCD66332211);
    wr(emacir_pkg::OFS_ADDR_LO, 32'h00000099, 4'h1);
    settle(8);
    chk(synced_address, 64'hABCD11332299);
    rd(emacir_pkg::OFS_EV_STAT, 32'h6);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_counters;
    t_time;
    t_wake;
    t_addr;
    finish_test;
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    #100000;
    fail_count++;
    finish_test;
  end
endmodule
